//--- dcrb_regs.svh
// dcrb_regs.svh: register addresses, field positions, reset values and timing counts
// assumes: included by bare name from the register bank sources
`ifndef DCRB_REGS_SVH
`define DCRB_REGS_SVH

`define DCRB_ADDR_W 5
`define DCRB_A_SPCFG 5'h00
`define DCRB_A_DIGCTL 5'h01
`define DCRB_A_FTW 5'h0A
`define DCRB_A_PHASE 5'h0B
`define DCRB_A_AMPL 5'h0C
`define DCRB_A_OFFS 5'h0D

`define DCRB_SP_SDIO_BIDIR 7
`define DCRB_SP_LSB_FIRST 6
`define DCRB_SP_SOFT_RST 5
`define DCRB_SP_FULL_PD 4
`define DCRB_SP_AUTO_PD 3
`define DCRB_SP_XFER 2
`define DCRB_SP_AUTO_XFER 1
`define DCRB_SPCFG_RST 8'h02
`define DCRB_SPCFG_MASK 8'hFA

`define DCRB_DC_PACC_CLR 14
`define DCRB_DC_CODE_SYNC 13
`define DCRB_DC_SYNC_SEL 12
`define DCRB_DC_PULSE_SYNC 11
`define DCRB_DC_SPEC_INV 10
`define DCRB_DC_INV_SINC 9
`define DCRB_DC_SCLK_OE 8
`define DCRB_DC_INTERP_HI 7
`define DCRB_DC_INTERP_LO 6
`define DCRB_DC_MISC_HI 5
`define DCRB_DIGCTL_RST 16'h0100
`define DCRB_DIGCTL_MASK 16'h7FFF

`define DCRB_FTW_RST 32'h00000000
`define DCRB_PHASE_RST 32'h00000000
`define DCRB_AMPL_RST 24'h010080
`define DCRB_OFFS_RST 32'h00000000

`define DCRB_MCLK_KHZ 125000
`define DCRB_WAKE_MS 250
`define DCRB_WAKE_CYCLES (`DCRB_WAKE_MS * `DCRB_MCLK_KHZ)
`define DCRB_AUTO_PD_IDLE_CYCLES 1024

`endif

//--- dcrb_pkg.sv
// dcrb_pkg.sv: types shared by the converter control register bank
// assumes: nothing beyond a SystemVerilog compiler
package dcrb_pkg;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_AUTO_LOW,
		PWR_DOWN,
		PWR_WAKE
	} dcrb_pwr_e;

	typedef struct packed {
		logic phase_acc_clear;
		logic code_sequence_sync_on;
		logic sync_sel_code;
		logic pulse_sync_on;
		logic spectral_invert;
		logic inv_sinc_on;
		logic sample_clock_out_oe;
		logic [1:0] interp_code;
		logic [3:0] interp_factor;
		logic [5:0] data_path_misc;
	} dcrb_ctrl_s;

	typedef struct packed {
		logic [31:0] ftw;
		logic [31:0] phase;
		logic [23:0] ampl;
		logic [31:0] offs;
	} dcrb_words_s;

endpackage

//--- dcrb_top.sv
// dcrb_top.sv: control register bank of a dual converter with complex oscillator
// assumes: a serial port controller on MCLK presents decoded register accesses,
// one strobe per completed register write or read; the gate pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "dcrb_regs.svh"

// Contract
// - full power-down holds everything until cleared; the code only sets the power outputs and stops the sample clock pin
// - auto power-down after long gate idle
// - transfer bit copies staged words together
// - transfer bit clears itself after copying
// - manual mode: staged writes wait for transfer
// - auto mode: writes apply right after completion
// - digital control: two bytes at 0x01
// - clear bit holds phase accumulator reset
// - code sync enable turns code mode on
// - select bit: pulse zero, code one
// - pulse sync enable turns pulse mode on
// - inversion bit picks low-side image
// - inverse sinc bit inserts filter when one
// - sample clock pin driven when bit one; the code holds it off in full power-down
// - interpolation code gives 1x 2x 4x 8x
// - both power-down bits reset to zero
// - configuration register: one byte at 0x00
module dcrb_top #(
	parameter int unsigned WAKE_CYCLES = `DCRB_WAKE_CYCLES,
	parameter int unsigned AUTO_PD_IDLE_CYCLES = `DCRB_AUTO_PD_IDLE_CYCLES
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// decoded register access
	input wire logic REG_WR_STB,
	input wire logic REG_RD_STB,
	input wire logic [`DCRB_ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_RD_VALID,
	// device pins
	input wire logic TRANSMIT_GATE_PIN,
	// control outputs
	output var dcrb_pkg::dcrb_ctrl_s CTRL,
	output var dcrb_pkg::dcrb_words_s WORDS,
	output logic [2:0] SERIAL_MODE,
	output logic XFER_DONE,
	// power state
	output logic FULL_POWER_DOWN,
	output logic LOW_POWER,
	output logic ANALOG_READY
);

	logic [7:0] spcfg_reg;
	logic xfer_pend_reg;
	logic auto_pend_reg;
	logic [15:0] digctl_reg;
	logic [31:0] ftw_reg;
	logic [31:0] phase_reg;
	logic [23:0] ampl_reg;
	logic [31:0] offs_reg;
	logic tx_meta_reg;
	logic tx_sync_reg;
	logic [31:0] idle_cnt_reg;
	logic [31:0] wake_cnt_reg;
	dcrb_pkg::dcrb_pwr_e pwr_reg;
	dcrb_pkg::dcrb_pwr_e pwr_next;
	logic wr_spcfg;
	logic wr_digctl;
	logic wr_stage;
	logic load_active;
	logic full_pd_bit;
	logic auto_pd_bit;
	logic idle_long;
	logic wake_done;

	// true for the four staged oscillator and correction words
	function automatic logic is_stage_addr(input logic [`DCRB_ADDR_W-1:0] a);
		is_stage_addr = (a == `DCRB_A_FTW) || (a == `DCRB_A_PHASE) ||
			(a == `DCRB_A_AMPL) || (a == `DCRB_A_OFFS);
	endfunction

	function automatic logic [3:0] interp_rate(input logic [1:0] code);
		case (code)
			2'h0: interp_rate = 4'h1;
			2'h1: interp_rate = 4'h2;
			2'h2: interp_rate = 4'h4;
			default: interp_rate = 4'h8;
		endcase
	endfunction

	assign wr_spcfg = REG_WR_STB && (REG_ADDR == `DCRB_A_SPCFG);
	assign wr_digctl = REG_WR_STB && (REG_ADDR == `DCRB_A_DIGCTL);
	assign wr_stage = REG_WR_STB && is_stage_addr(REG_ADDR);
	assign load_active = xfer_pend_reg || auto_pend_reg;
	assign full_pd_bit = spcfg_reg[`DCRB_SP_FULL_PD];
	assign auto_pd_bit = spcfg_reg[`DCRB_SP_AUTO_PD];
	assign idle_long = (idle_cnt_reg == 32'(AUTO_PD_IDLE_CYCLES));
	assign wake_done = (wake_cnt_reg >= 32'(WAKE_CYCLES - 1));

	// configuration byte; the transfer bit lives in its own flop
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			spcfg_reg <= `DCRB_SPCFG_RST;
		end else if (wr_spcfg) begin
			spcfg_reg <= REG_WDATA[7:0] & `DCRB_SPCFG_MASK;
		end
	end

	// a new request in the copy cycle stays pending
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			xfer_pend_reg <= 1'b0;
		end else if (wr_spcfg && REG_WDATA[`DCRB_SP_XFER]) begin
			xfer_pend_reg <= 1'b1;
		end else if (xfer_pend_reg) begin
			xfer_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			auto_pend_reg <= 1'b0;
		end else begin
			auto_pend_reg <= wr_stage && spcfg_reg[`DCRB_SP_AUTO_XFER];
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			digctl_reg <= `DCRB_DIGCTL_RST;
		end else if (wr_digctl) begin
			digctl_reg <= REG_WDATA[15:0] & `DCRB_DIGCTL_MASK;
		end
	end

	// staged words
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			ftw_reg <= `DCRB_FTW_RST;
			phase_reg <= `DCRB_PHASE_RST;
			ampl_reg <= `DCRB_AMPL_RST;
			offs_reg <= `DCRB_OFFS_RST;
		end else if (REG_WR_STB) begin
			if (REG_ADDR == `DCRB_A_FTW) begin
				ftw_reg <= REG_WDATA;
			end
			if (REG_ADDR == `DCRB_A_PHASE) begin
				phase_reg <= REG_WDATA;
			end
			if (REG_ADDR == `DCRB_A_AMPL) begin
				ampl_reg <= REG_WDATA[23:0];
			end
			if (REG_ADDR == `DCRB_A_OFFS) begin
				offs_reg <= REG_WDATA;
			end
		end
	end

	// active words change only together
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			WORDS.ftw <= `DCRB_FTW_RST;
			WORDS.phase <= `DCRB_PHASE_RST;
			WORDS.ampl <= `DCRB_AMPL_RST;
			WORDS.offs <= `DCRB_OFFS_RST;
		end else if (load_active) begin
			WORDS.ftw <= ftw_reg;
			WORDS.phase <= phase_reg;
			WORDS.ampl <= ampl_reg;
			WORDS.offs <= offs_reg;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			XFER_DONE <= 1'b0;
		end else begin
			XFER_DONE <= load_active;
		end
	end

	// digital control fields towards the datapath
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			CTRL <= '0;
			SERIAL_MODE <= 3'h0;
		end else begin
			CTRL.phase_acc_clear <= digctl_reg[`DCRB_DC_PACC_CLR];
			CTRL.code_sequence_sync_on <= digctl_reg[`DCRB_DC_CODE_SYNC];
			CTRL.sync_sel_code <= digctl_reg[`DCRB_DC_SYNC_SEL];
			CTRL.pulse_sync_on <= digctl_reg[`DCRB_DC_PULSE_SYNC];
			CTRL.spectral_invert <= digctl_reg[`DCRB_DC_SPEC_INV];
			CTRL.inv_sinc_on <= digctl_reg[`DCRB_DC_INV_SINC];
			CTRL.sample_clock_out_oe <= digctl_reg[`DCRB_DC_SCLK_OE] &&
				(pwr_next != dcrb_pkg::PWR_DOWN);
			CTRL.interp_code <= digctl_reg[`DCRB_DC_INTERP_HI:`DCRB_DC_INTERP_LO];
			CTRL.interp_factor <= interp_rate(
				digctl_reg[`DCRB_DC_INTERP_HI:`DCRB_DC_INTERP_LO]);
			CTRL.data_path_misc <= digctl_reg[`DCRB_DC_MISC_HI:0];
			SERIAL_MODE <= spcfg_reg[`DCRB_SP_SDIO_BIDIR:`DCRB_SP_SOFT_RST];
		end
	end

	// gate pin synchroniser
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			tx_meta_reg <= 1'b0;
			tx_sync_reg <= 1'b0;
		end else begin
			tx_meta_reg <= TRANSMIT_GATE_PIN;
			tx_sync_reg <= tx_meta_reg;
		end
	end

	// saturating count of cycles with the gate low
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			idle_cnt_reg <= 32'h00000000;
		end else if (tx_sync_reg) begin
			idle_cnt_reg <= 32'h00000000;
		end else if (!idle_long) begin
			idle_cnt_reg <= idle_cnt_reg + 32'h00000001;
		end
	end

	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			dcrb_pkg::PWR_RUN: begin
				if (full_pd_bit) begin
					pwr_next = dcrb_pkg::PWR_DOWN;
				end else if (auto_pd_bit && idle_long) begin
					pwr_next = dcrb_pkg::PWR_AUTO_LOW;
				end
			end
			dcrb_pkg::PWR_AUTO_LOW: begin
				if (full_pd_bit) begin
					pwr_next = dcrb_pkg::PWR_DOWN;
				end else if (!auto_pd_bit || tx_sync_reg) begin
					pwr_next = dcrb_pkg::PWR_RUN;
				end
			end
			dcrb_pkg::PWR_DOWN: begin
				if (!full_pd_bit) begin
					pwr_next = dcrb_pkg::PWR_WAKE;
				end
			end
			dcrb_pkg::PWR_WAKE: begin
				if (full_pd_bit) begin
					pwr_next = dcrb_pkg::PWR_DOWN;
				end else if (wake_done) begin
					pwr_next = dcrb_pkg::PWR_RUN;
				end
			end
			default: begin
				pwr_next = dcrb_pkg::PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			pwr_reg <= dcrb_pkg::PWR_RUN;
		end else begin
			pwr_reg <= pwr_next;
		end
	end

	// analog settling time after leaving full power-down
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			wake_cnt_reg <= 32'h00000000;
		end else if (pwr_reg == dcrb_pkg::PWR_WAKE) begin
			wake_cnt_reg <= wake_cnt_reg + 32'h00000001;
		end else begin
			wake_cnt_reg <= 32'h00000000;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			FULL_POWER_DOWN <= 1'b0;
			LOW_POWER <= 1'b0;
			ANALOG_READY <= 1'b1;
		end else begin
			FULL_POWER_DOWN <= (pwr_next == dcrb_pkg::PWR_DOWN);
			LOW_POWER <= (pwr_next == dcrb_pkg::PWR_DOWN) ||
				(pwr_next == dcrb_pkg::PWR_AUTO_LOW);
			ANALOG_READY <= (pwr_next == dcrb_pkg::PWR_RUN) ||
				(pwr_next == dcrb_pkg::PWR_AUTO_LOW);
		end
	end

	// readback; unmapped addresses read zero
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
			REG_RD_VALID <= 1'b0;
		end else begin
			REG_RD_VALID <= REG_RD_STB;
			if (REG_RD_STB) begin
				case (REG_ADDR)
					`DCRB_A_SPCFG: REG_RDATA <= {24'h000000, spcfg_reg[7:3],
						xfer_pend_reg, spcfg_reg[1:0]};
					`DCRB_A_DIGCTL: REG_RDATA <= {16'h0000, digctl_reg};
					`DCRB_A_FTW: REG_RDATA <= ftw_reg;
					`DCRB_A_PHASE: REG_RDATA <= phase_reg;
					`DCRB_A_AMPL: REG_RDATA <= {8'h00, ampl_reg};
					`DCRB_A_OFFS: REG_RDATA <= offs_reg;
					default: REG_RDATA <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

//--- dcrb_host.sv
// dcrb_host.sv: host model issuing decoded register writes and reads
// assumes: shares mclk with the bank and drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module dcrb_host (
	// clock
	input wire logic mclk,
	// register access
	output logic wr,
	output logic rd,
	output logic [4:0] adr,
	output logic [31:0] wd,
	input wire logic [31:0] rdat,
	input wire logic rv
);
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		adr = 5'h1F;
		wd = 32'h0;
	end
	// released lines show the inverse so stale values never pass
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(negedge mclk);
		wr = 1'b1;
		adr = a;
		wd = d;
		@(negedge mclk);
		wr = 1'b0;
		adr = ~a;
		wd = ~d;
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d, output logic ok);
		@(negedge mclk);
		rd = 1'b1;
		adr = a;
		@(negedge mclk);
		rd = 1'b0;
		adr = ~a;
		ok = rv;
		d = rdat;
	endtask
	// manual mode needs an explicit transfer request
	task automatic xfer(input logic [7:0] cfg);
		wr_reg(5'h00, {24'h0, cfg | 8'h04});
	endtask
endmodule
`default_nettype wire

//--- dcrb_top_chk.sv
// dcrb_top_chk.sv: port assertions for the register bank, bound to dcrb_top
// assumes: one clock domain, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dcrb_top_chk (
	// clock, reset and register access
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic REG_WR_STB,
	input wire logic REG_RD_STB,
	input wire logic [4:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic REG_RD_VALID,
	// outputs
	input wire dcrb_pkg::dcrb_ctrl_s CTRL,
	input wire dcrb_pkg::dcrb_words_s WORDS,
	input wire logic XFER_DONE,
	input wire logic FULL_POWER_DOWN,
	input wire logic LOW_POWER,
	input wire logic ANALOG_READY
);
	logic auto_reg;
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			auto_reg <= 1'b1;
		else if (REG_WR_STB && REG_ADDR == 5'h00)
			auto_reg <= REG_WDATA[1];
	end
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	sequence s_stage_wr;
		REG_WR_STB && auto_reg && REG_ADDR >= 5'h0A && REG_ADDR <= 5'h0D;
	endsequence
	sequence s_pd_wr;
		REG_WR_STB && REG_ADDR == 5'h00 && REG_WDATA[4];
	endsequence
	sequence s_dc_wr;
		REG_WR_STB && REG_ADDR == 5'h01;
	endsequence
	property p_auto_apply;
		s_stage_wr |-> ##2 XFER_DONE;
	endproperty
	a_auto_apply: assert property (p_auto_apply) else $error("write not applied");
	property p_words_move;
		!$stable(WORDS) |-> XFER_DONE;
	endproperty
	a_words_move: assert property (p_words_move) else $error("words moved alone");
	property p_pd_enter;
		s_pd_wr |-> ##2 FULL_POWER_DOWN && LOW_POWER && !ANALOG_READY;
	endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("no power down");
	property p_rd_cfg;
		REG_RD_STB && REG_ADDR == 5'h00 |=> REG_RD_VALID && REG_RDATA[31:8] == 24'h0;
	endproperty
	a_rd_cfg: assert property (p_rd_cfg) else $error("bad config read");
	property p_rd_dc;
		REG_RD_STB && REG_ADDR == 5'h01 |=> REG_RD_VALID && REG_RDATA[31:15] == 17'h0;
	endproperty
	a_rd_dc: assert property (p_rd_dc) else $error("bad control read");
	property p_interp;
		$past(RST_N) |-> CTRL.interp_factor == (4'h1 << CTRL.interp_code);
	endproperty
	a_interp: assert property (p_interp) else $error("bad factor");
	property p_dc_fields;
		s_dc_wr |-> ##2 CTRL[18:13] == $past(REG_WDATA[14:9], 2);
	endproperty
	a_dc_fields: assert property (p_dc_fields) else $error("bad flags");
	property p_reset_pd;
		disable iff (1'b0) !RST_N |=> !FULL_POWER_DOWN && !LOW_POWER;
	endproperty
	a_reset_pd: assert property (p_reset_pd) else $error("power down after reset");
endmodule
bind dcrb_top dcrb_top_chk chk (.MCLK(MCLK), .RST_N(RST_N), .REG_WR_STB(REG_WR_STB),
	.REG_RD_STB(REG_RD_STB), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_RD_VALID(REG_RD_VALID), .CTRL(CTRL), .WORDS(WORDS), .XFER_DONE(XFER_DONE),
	.FULL_POWER_DOWN(FULL_POWER_DOWN), .LOW_POWER(LOW_POWER), .ANALOG_READY(ANALOG_READY));
`default_nettype wire

//--- tb.sv
// tb.sv: self-checking bench for the converter control register bank
// assumes: dcrb_top, dcrb_host and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic MCLK, RST_N, gate, wr, rd, rv, xd, fpd, lp, ar, ok;
	logic [4:0] adr;
	logic [31:0] wd, rdat, st, d, got;
	logic [2:0] smode;
	logic [31:0] w [4];
	dcrb_pkg::dcrb_ctrl_s ctrl;
	dcrb_pkg::dcrb_words_s words, old;
	int n_errors, check_count, i;
	dcrb_top #(.WAKE_CYCLES(20), .AUTO_PD_IDLE_CYCLES(8)) uut (.MCLK(MCLK), .RST_N(RST_N),
		.REG_WR_STB(wr), .REG_RD_STB(rd), .REG_ADDR(adr), .REG_WDATA(wd), .REG_RDATA(rdat),
		.REG_RD_VALID(rv), .TRANSMIT_GATE_PIN(gate), .CTRL(ctrl), .WORDS(words),
		.SERIAL_MODE(smode), .XFER_DONE(xd), .FULL_POWER_DOWN(fpd), .LOW_POWER(lp),
		.ANALOG_READY(ar));
	dcrb_host host (.mclk(MCLK), .wr(wr), .rd(rd), .adr(adr), .wd(wd), .rdat(rdat), .rv(rv));
	function automatic logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	function automatic logic [3:0] fac(input logic [1:0] c);
		return 4'h1 << c;
	endfunction
	function automatic logic [31:0] dc_exp(input logic [31:0] v);
		return {16'h0, v[15:0] & 16'h7FFF};
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic to(input logic flag);
		if (flag !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: wait ran out", $time);
			end_sim();
		end
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		host.rd_reg(a, got, ok);
		chk(ok, 1'b1);
		chk(got, e);
	endtask
	always #4 MCLK = ~MCLK;
	initial begin
		MCLK = 1'b0;
		RST_N = 1'b0;
		gate = 1'b1;
		st = 32'h00005F8E;
		n_errors = 0;
		check_count = 0;
		repeat (6) @(negedge MCLK);
		RST_N = 1'b1;
		rd_chk(5'h00, 32'h02);
		rd_chk(5'h01, 32'h0100);
		chk(words.ampl, 24'h010080);
		$display("test reset done");
		w[0] = xs();
		host.wr_reg(5'h0A, w[0]);
		repeat (2) @(negedge MCLK);
		chk(words.ftw, w[0]);
		$display("test auto update done");
		host.wr_reg(5'h00, 32'h0);
		old = words;
		for (i = 0; i < 4; i++) begin
			w[i] = xs();
			host.wr_reg(5'h0A + i[4:0], w[i]);
		end
		repeat (3) @(negedge MCLK);
		chk(words, old);
		host.xfer(8'h00);
		for (i = 0; i < 8 && xd !== 1'b1; i++) @(negedge MCLK);
		to(xd);
		chk(words, {w[0], w[1], w[2][23:0], w[3]});
		rd_chk(5'h00, 32'h0);
		rd_chk(5'h0C, {8'h00, w[2][23:0]});
		host.wr_reg(5'h00, 32'h02);
		$display("test manual update done");
		for (i = 0; i < 4; i++) begin
			d = xs();
			d[15] = 1'b1;
			d[7:6] = i[1:0];
			host.wr_reg(5'h01, d);
			repeat (2) @(negedge MCLK);
			chk(ctrl.interp_factor, fac(i[1:0]));
			chk(ctrl.data_path_misc, d[5:0]);
			chk(ctrl[18:10], d[14:6]);
			rd_chk(5'h01, dc_exp(d));
		end
		$display("test control done");
		d = (xs() & 32'h000000E0) | 32'h00000002;
		host.wr_reg(5'h00, d);
		repeat (2) @(negedge MCLK);
		chk(smode, d[7:5]);
		rd_chk(5'h00, d);
		$display("test serial mode done");
		host.wr_reg(5'h01, 32'h0100);
		host.wr_reg(5'h00, 32'h12);
		repeat (2) @(negedge MCLK);
		chk({fpd, lp, ar, ctrl.sample_clock_out_oe}, 4'hC);
		host.wr_reg(5'h00, 32'h02);
		for (i = 0; i < 40 && ar !== 1'b1; i++) @(negedge MCLK);
		to(ar);
		chk({fpd, ctrl.sample_clock_out_oe}, 2'b01);
		$display("test power down done");
		gate = 1'b0;
		repeat (20) @(negedge MCLK);
		chk(lp, 1'b0);
		host.wr_reg(5'h00, 32'h0A);
		for (i = 0; i < 30 && lp !== 1'b1; i++) @(negedge MCLK);
		to(lp);
		chk(fpd, 1'b0);
		gate = 1'b1;
		repeat (5) @(negedge MCLK);
		chk(lp, 1'b0);
		$display("test auto power down done");
		host.wr_reg(5'h00, 32'h12);
		repeat (2) @(negedge MCLK);
		chk(fpd, 1'b1);
		RST_N = 1'b0;
		repeat (2) @(negedge MCLK);
		RST_N = 1'b1;
		chk({fpd, lp, ar, xd}, 4'h2);
		chk(words, {64'h0, 24'h010080, 32'h0});
		rd_chk(5'h00, 32'h02);
		rd_chk(5'h01, 32'h0100);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule
`default_nettype wire
